// >>> input_modules_model.sv
// Model of the two redundant input modules and their update pacing.
// Assumes the bench places wanted channel values on the request ports.
`timescale 1ns/1ps
module input_modules_model #(parameter int TICK_DIV = 64)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Wanted readings
  input wire voter_pkg::dig_pair_t dig_req_in,
  input wire voter_pkg::ana_pair_t ana_req_in,
  // To the voter
  output logic tick_out,
  output voter_pkg::dig_pair_t dig_out,
  output voter_pkg::ana_pair_t ana_out
);
  int cnt;
  // ==========
  // Fixed update period; readings move only at a tick, so every
  // discrepancy time the bench sets is whole periods
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 0;
      tick_out <= 1'b0;
      dig_out <= '0;
      ana_out <= '0;
    end
    else
    begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      tick_out <= (cnt == TICK_DIV - 1);
      if (tick_out)
      begin
        // A channel may be held stuck at one level on purpose
        dig_out <= dig_req_in;
        ana_out <= ana_req_in;
      end
    end
  end
endmodule

// >>> redundant_input_voter.sv
// Voter for redundant digital and analog input pairs with APB registers.
// Assumes inputs and update tick come from logic on clock_in; one master.
//
// Functional notes
// - Agreeing digital pair writes common value.
// - First disagreement marks channel, starts timer.
// - During timer, hold last agreed digital value.
// - Repeat until match or timer expiry.
// - Digital expiry raises 7960, no passivation.
// - After expiry apply configured response.
// - First change after expiry passivates other.
// - Analog equal within percent-of-full-scale window.
// - Agreeing analog pair writes applied value.
// - During analog timer, write last valid.
// - Analog expiry keeps standard channel, passivates other.
// - Minimum standard passivates maximum-reading channel.
// - Analog passivations logged in diagnostic buffer.
// - Discrepancy cleared early keeps normal comparison.
// - Overflow or underflow passivates channel immediately.
// - Stuck-at-one or zero shows as discrepancy.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module redundant_input_voter
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Redundant inputs
  input wire logic update_tick_in,
  input wire voter_pkg::dig_pair_t dig_in,
  input wire voter_pkg::ana_pair_t ana_in,
  // Process image and status
  output logic [voter_pkg::DIG_W-1:0] dig_image_out,
  output logic [voter_pkg::ANA_W-1:0] ana_image_out,
  output logic unloc_err_out,
  output logic irq_out
);

  // ==========================================================
  // State
  voter_pkg::state_t r;
  voter_pkg::state_t n;

  logic acc;
  logic setup;
  logic hit;
  logic [7:0] ofs;
  logic [voter_pkg::EV_W-1:0] ev;
  logic [voter_pkg::TMR_W-1:0] t;
  logic [voter_pkg::ANA_W-1:0] a;
  logic [voter_pkg::ANA_W-1:0] b;
  logic [voter_pkg::ANA_W:0] diff;
  logic [22:0] tol_prod;
  logic [voter_pkg::ANA_W:0] tol_abs;
  logic [1:0] push_v;
  logic [1:0][2:0] push_e;
  logic [31:0] rdv;

  assign ofs = paddr_in[7:0];
  assign setup = psel_in & ~penable_in;
  assign acc = psel_in & penable_in;
  assign hit = (paddr_in[31:8] == 24'h0) && (ofs[1:0] == 2'h0) && (ofs <= voter_pkg::OFS_AIMG);
  assign pready_out = acc;
  // Unmapped words answer with an error, no side effect
  assign pslverr_out = acc & ~hit;
  assign prdata_out = r.prdata;
  assign dig_image_out = r.d_img;
  assign ana_image_out = r.a_img;
  assign unloc_err_out = r.err_pulse;
  assign irq_out = |(r.irq_sts & r.irq_en);

  // Window is a percentage of the range end value
  assign tol_prod = 23'(voter_pkg::ANA_FULL) * 23'(r.tol);
  assign tol_abs = 17'(tol_prod / 23'(voter_pkg::PCT_DIV));

  // ==========================================================
  // Read mux
  always_comb
  begin
    rdv = 32'h0;
    unique case (ofs)
      voter_pkg::OFS_CTRL: rdv = 32'(r.ctrl);
      voter_pkg::OFS_DISC: rdv = 32'(r.disc);
      voter_pkg::OFS_TOL: rdv = 32'(r.tol);
      voter_pkg::OFS_DPASS_A: rdv = 32'(r.d_pass_a);
      voter_pkg::OFS_DPASS_B: rdv = 32'(r.d_pass_b);
      voter_pkg::OFS_ASTAT: rdv = 32'({r.a_mark, r.a_pass_b, r.a_pass_a});
      voter_pkg::OFS_IRQ_STS: rdv = 32'(r.irq_sts);
      voter_pkg::OFS_IRQ_EN: rdv = 32'(r.irq_en);
      voter_pkg::OFS_ERR: rdv = 32'(r.err);
      voter_pkg::OFS_DIAG: rdv = 32'({r.cnt, 1'b0, r.diag[r.rd]});
      voter_pkg::OFS_DIMG: rdv = 32'(r.d_img);
      voter_pkg::OFS_AIMG: rdv = 32'(r.a_img);
      default: rdv = 32'h0;
    endcase
    if (!hit)
    begin
      rdv = 32'h0;
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    n = r;
    ev = '0;
    t = '0;
    push_v = '0;
    push_e = '0;
    a = ana_in.a;
    b = ana_in.b;
    diff = '0;
    n.err_pulse = 1'b0;

    // Read data is captured in the setup phase so it comes from a flop
    if (setup)
    begin
      n.prdata = rdv;
    end

    // Register writes; clears go first so hardware sets below win
    if (acc && hit && pwrite_in)
    begin
      unique case (ofs)
        voter_pkg::OFS_CTRL: n.ctrl = pwdata_in[2:0];
        voter_pkg::OFS_DISC: n.disc = pwdata_in[voter_pkg::TMR_W-1:0];
        voter_pkg::OFS_TOL: n.tol = pwdata_in[6:0];
        voter_pkg::OFS_DRESET:
        begin
          n.d_pass_a = r.d_pass_a & ~pwdata_in[voter_pkg::DIG_W-1:0];
          n.d_pass_b = r.d_pass_b & ~pwdata_in[voter_pkg::DIG_W-1:0];
          n.d_exp = r.d_exp & ~pwdata_in[voter_pkg::DIG_W-1:0];
          n.d_mark = r.d_mark & ~pwdata_in[voter_pkg::DIG_W-1:0];
        end
        voter_pkg::OFS_ARESET:
        begin
          if (pwdata_in[0])
          begin
            n.a_pass_a = 1'b0;
            n.a_pass_b = 1'b0;
            n.a_mark = 1'b0;
          end
        end
        voter_pkg::OFS_IRQ_CLR: n.irq_sts = r.irq_sts & ~pwdata_in[voter_pkg::EV_W-1:0];
        voter_pkg::OFS_IRQ_EN: n.irq_en = pwdata_in[voter_pkg::EV_W-1:0];
        default: n.ctrl = r.ctrl;
      endcase
    end

    // Reading the diagnostic word pops the oldest entry
    if (acc && hit && !pwrite_in && ofs == voter_pkg::OFS_DIAG && r.cnt != '0)
    begin
      n.rd = r.rd + 1'b1;
      n.cnt = r.cnt - 1'b1;
    end

    if (update_tick_in)
    begin
      // ------------------------------------------------------
      // Digital pairs
      for (int i = 0; i < voter_pkg::DIG_W; i++)
      begin
        t = '0;
        if (n.d_pass_a[i])
        begin
          n.d_img[i] = dig_in.b[i];
        end
        else if (n.d_pass_b[i])
        begin
          n.d_img[i] = dig_in.a[i];
        end
        else if (n.d_exp[i])
        begin
          // The side that moves first is taken as intact
          if (dig_in.a[i] != r.d_prev_a[i])
          begin
            n.d_pass_b[i] = 1'b1;
            n.d_img[i] = dig_in.a[i];
            n.d_exp[i] = 1'b0;
            n.d_mark[i] = 1'b0;
            ev[voter_pkg::EV_DPASS] = 1'b1;
          end
          else if (dig_in.b[i] != r.d_prev_b[i])
          begin
            n.d_pass_a[i] = 1'b1;
            n.d_img[i] = dig_in.b[i];
            n.d_exp[i] = 1'b0;
            n.d_mark[i] = 1'b0;
            ev[voter_pkg::EV_DPASS] = 1'b1;
          end
          else
          begin
            // Response: hold last agreed, or force zero
            n.d_img[i] = r.ctrl[voter_pkg::CTRL_RESP_BIT] ? 1'b0 : r.d_last[i];
          end
        end
        else if (dig_in.a[i] == dig_in.b[i])
        begin
          n.d_img[i] = dig_in.a[i];
          n.d_last[i] = dig_in.a[i];
          n.d_mark[i] = 1'b0;
          n.d_tmr[i] = '0;
        end
        else
        begin
          // A stuck input differs from its partner on the next edge
          t = n.d_mark[i] ? r.d_tmr[i] + 1'b1 : '0;
          n.d_mark[i] = 1'b1;
          n.d_tmr[i] = t;
          n.d_img[i] = r.d_last[i];
          if (t >= r.disc)
          begin
            n.d_exp[i] = 1'b1;
            n.err = voter_pkg::ERR_DIG_UNLOC;
            n.err_pulse = 1'b1;
            ev[voter_pkg::EV_DERR] = 1'b1;
          end
        end
      end
      n.d_prev_a = dig_in.a;
      n.d_prev_b = dig_in.b;

      // ------------------------------------------------------
      // Analog pair
      if (!n.a_pass_a && (a == voter_pkg::ANA_OVF || a == voter_pkg::ANA_UDF))
      begin
        n.a_pass_a = 1'b1;
        push_v[0] = 1'b1;
        push_e[0] = {voter_pkg::DIAG_OVF, 1'b0};
        ev[voter_pkg::EV_AOVF] = 1'b1;
      end
      if (!n.a_pass_b && (b == voter_pkg::ANA_OVF || b == voter_pkg::ANA_UDF))
      begin
        n.a_pass_b = 1'b1;
        push_v[1] = 1'b1;
        push_e[1] = {voter_pkg::DIAG_OVF, 1'b1};
        ev[voter_pkg::EV_AOVF] = 1'b1;
      end
      // Sign-extend before subtracting so opposite-sign readings cannot wrap
      diff = ($signed(a) >= $signed(b)) ? ({a[voter_pkg::ANA_W-1], a} - {b[voter_pkg::ANA_W-1], b})
        : ({b[voter_pkg::ANA_W-1], b} - {a[voter_pkg::ANA_W-1], a});
      t = '0;
      if (n.a_pass_a && n.a_pass_b)
      begin
        n.a_img = r.a_img;
      end
      else if (n.a_pass_a)
      begin
        n.a_img = b;
      end
      else if (n.a_pass_b)
      begin
        n.a_img = a;
      end
      else if (diff <= tol_abs)
      begin
        n.a_img = r.ctrl[voter_pkg::CTRL_APPLY_BIT] ? b : a;
        n.a_last = n.a_img;
        n.a_mark = 1'b0;
        n.a_tmr = '0;
      end
      else
      begin
        t = n.a_mark ? r.a_tmr + 1'b1 : '0;
        n.a_mark = 1'b1;
        n.a_tmr = t;
        n.a_img = r.a_last;
        if (t >= r.disc)
        begin
          n.a_mark = 1'b0;
          ev[voter_pkg::EV_APASS] = 1'b1;
          push_v[0] = 1'b1;
          // Keep the standard channel, drop the other
          if (r.ctrl[voter_pkg::CTRL_STDMAX_BIT] == ($signed(a) >= $signed(b)))
          begin
            n.a_pass_b = 1'b1;
            n.a_img = a;
            push_e[0] = {voter_pkg::DIAG_DISC, 1'b1};
          end
          else
          begin
            n.a_pass_a = 1'b1;
            n.a_img = b;
            push_e[0] = {voter_pkg::DIAG_DISC, 1'b0};
          end
        end
      end

      // Full buffer overwrites the oldest entry
      for (int k = 0; k < 2; k++)
      begin
        if (push_v[k])
        begin
          n.diag[n.wr] = push_e[k];
          n.wr = n.wr + 1'b1;
          if (n.cnt == (voter_pkg::DIAG_PW+1)'(voter_pkg::DIAG_DEPTH))
          begin
            n.rd = n.rd + 1'b1;
          end
          else
          begin
            n.cnt = n.cnt + 1'b1;
          end
        end
      end
    end

    n.irq_sts = n.irq_sts | ev;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
      r.ctrl <= voter_pkg::CTRL_RST;
      r.disc <= voter_pkg::DISC_RST;
      r.tol <= voter_pkg::TOL_RST;
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// >>> tb.sv
// Self-checking bench for the redundant input voter.
// Assumes the input model paces updates; bench is the APB master.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, update_tick_in, unloc_err_out, irq_out;
  voter_pkg::dig_pair_t dig_in;
  voter_pkg::ana_pair_t ana_in;
  voter_pkg::dig_pair_t dig_req = '0;
  voter_pkg::ana_pair_t ana_req = '0;
  logic [7:0] dig_image_out;
  logic [15:0] ana_image_out;
  logic [31:0] rd;
  logic se;
  logic [31:0] bad [2] = '{32'h7fff_2000, 32'h2000_8000};
  int err_count = 0;
  int n_compared = 0;
  always #12.5 clock_in = ~clock_in;
  redundant_input_voter dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .update_tick_in(update_tick_in), .dig_in(dig_in),
    .ana_in(ana_in), .dig_image_out(dig_image_out), .ana_image_out(ana_image_out),
    .unloc_err_out(unloc_err_out), .irq_out(irq_out));
  input_modules_model #(.TICK_DIV(64)) model (.clock_in(clock_in), .rst_n_in(rst_n_in), .dig_req_in(dig_req),
    .ana_req_in(ana_req), .tick_out(update_tick_in), .dig_out(dig_in), .ana_out(ana_in));
  // ==========
  // Bus and pacing tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {24'h0, a};
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock_in);
      if (pready_out === 1'b1)
        break;
    end
    rd = prdata_out;
    se = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1;
    if (i == 20)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Returns just after the n-th tick edge, while one-cycle pulses stand
  task automatic ticks(input int n);
    int i;
    repeat (n)
    begin
      for (i = 0; i < 200; i++)
      begin
        @(posedge clock_in);
        if (update_tick_in === 1'b1)
          break;
      end
      if (i == 200)
      begin
        err_count++;
        tally_and_finish();
      end
    end
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rchk(voter_pkg::OFS_CTRL, 32'h2);
    rchk(voter_pkg::OFS_DISC, 32'ha);
    rchk(voter_pkg::OFS_TOL, 32'h5);
    rchk(8'h3c, 32'h0);
    `CHK(se, 1'b1)
    $display("test reset done");
    apb(1'b1, voter_pkg::OFS_DISC, 32'h2);
    apb(1'b1, voter_pkg::OFS_IRQ_EN, 32'hf);
    dig_req <= 16'h5a5a;
    ticks(2);
    `CHK(dig_image_out, 8'h5a)
    dig_req <= 16'h5b5a;
    ticks(2);
    `CHK(dig_image_out, 8'h5a)
    ticks(1);
    `CHK(dig_image_out, 8'h5a)
    ticks(1);
    `CHK(unloc_err_out, 1'b1)
    `CHK(dig_image_out, 8'h5a)
    rchk(voter_pkg::OFS_ERR, 32'h1f18);
    rchk(voter_pkg::OFS_DPASS_A, 32'h0);
    rchk(voter_pkg::OFS_DPASS_B, 32'h0);
    `CHK(irq_out, 1'b1)
    dig_req <= 16'h5b5b;
    ticks(2);
    `CHK(dig_image_out, 8'h5b)
    rchk(voter_pkg::OFS_DPASS_A, 32'h1);
    dig_req <= 16'h5a5b;
    ticks(2);
    `CHK(dig_image_out, 8'h5b)
    rchk(voter_pkg::OFS_IRQ_STS, 32'h3);
    apb(1'b1, voter_pkg::OFS_IRQ_EN, 32'h0);
    `CHK(irq_out, 1'b0)
    apb(1'b1, voter_pkg::OFS_IRQ_EN, 32'hf);
    apb(1'b1, voter_pkg::OFS_IRQ_CLR, 32'hf);
    `CHK(irq_out, 1'b0)
    // Agreeing pair first, so the cleared bit does not expire again
    dig_req <= 16'h5b5b;
    apb(1'b1, voter_pkg::OFS_DRESET, 32'hff);
    rchk(voter_pkg::OFS_DPASS_A, 32'h0);
    ticks(2);
    `CHK(dig_image_out, 8'h5b)
    apb(1'b1, voter_pkg::OFS_CTRL, 32'h1);
    dig_req <= 16'h5b5a;
    ticks(5);
    `CHK(dig_image_out, 8'h5a)
    dig_req <= 16'h5b5b;
    apb(1'b1, voter_pkg::OFS_DRESET, 32'hff);
    ticks(2);
    `CHK(dig_image_out, 8'h5b)
    apb(1'b1, voter_pkg::OFS_IRQ_CLR, 32'hf);
    $display("test digital done");
    apb(1'b1, voter_pkg::OFS_CTRL, 32'h6);
    ana_req <= 32'h1000_1100;
    ticks(2);
    `CHK(ana_image_out, 16'h1100)
    ana_req <= 32'h1000_3000;
    ticks(2);
    `CHK(ana_image_out, 16'h1100)
    apb(1'b0, voter_pkg::OFS_ASTAT, 32'h0);
    `CHK(rd[2], 1'b1)
    ana_req <= 32'h1200_1200;
    ticks(2);
    `CHK(ana_image_out, 16'h1200)
    rchk(voter_pkg::OFS_ASTAT, 32'h0);
    apb(1'b1, voter_pkg::OFS_CTRL, 32'h2);
    ana_req <= 32'h1000_3000;
    ticks(4);
    `CHK(ana_image_out, 16'h3000)
    apb(1'b0, voter_pkg::OFS_ASTAT, 32'h0);
    `CHK(rd[1:0], 2'h1)
    rchk(voter_pkg::OFS_DIAG, 32'h12);
    apb(1'b1, voter_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, voter_pkg::OFS_ARESET, 32'h1);
    ticks(3);
    `CHK(ana_image_out, 16'h1000)
    apb(1'b0, voter_pkg::OFS_ASTAT, 32'h0);
    `CHK(rd[1:0], 2'h2)
    rchk(voter_pkg::OFS_DIAG, 32'h13);
    // Agreeing pair first, so a stale bad reading is not seen after clear
    for (int k = 0; k < 2; k++)
    begin
      ana_req <= 32'h2000_2000;
      ticks(1);
      apb(1'b1, voter_pkg::OFS_ARESET, 32'h1);
      ana_req <= bad[k];
      ticks(2);
      `CHK(ana_image_out, 16'h2000)
      apb(1'b0, voter_pkg::OFS_ASTAT, 32'h0);
      `CHK(rd[1:0], 2'(k + 1))
      rchk(voter_pkg::OFS_DIAG, 32'h14 + k);
    end
    rchk(voter_pkg::OFS_IRQ_STS, 32'hc);
    $display("test analog done");
    tally_and_finish();
  end
endmodule

// >>> voter_pkg.sv
// Constants, register map and carrier types for the redundant input voter.
// Assumes one 40 MHz clock and an APB master on the same clock.
package voter_pkg;

  // ==========================================================
  // Sizes
  localparam int DIG_W = 8;
  localparam int ANA_W = 16;
  localparam int TMR_W = 16;
  localparam int DIAG_DEPTH = 8;
  localparam int DIAG_PW = 3;
  localparam int EV_W = 4;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DISC = 8'h04;
  localparam logic [7:0] OFS_TOL = 8'h08;
  localparam logic [7:0] OFS_DPASS_A = 8'h0c;
  localparam logic [7:0] OFS_DPASS_B = 8'h10;
  localparam logic [7:0] OFS_DRESET = 8'h14;
  localparam logic [7:0] OFS_ASTAT = 8'h18;
  localparam logic [7:0] OFS_ARESET = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] OFS_ERR = 8'h2c;
  localparam logic [7:0] OFS_DIAG = 8'h30;
  localparam logic [7:0] OFS_DIMG = 8'h34;
  localparam logic [7:0] OFS_AIMG = 8'h38;

  // ==========================================================
  // Fields and reset values
  localparam int CTRL_RESP_BIT = 0;
  localparam int CTRL_STDMAX_BIT = 1;
  localparam int CTRL_APPLY_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [TMR_W-1:0] DISC_RST = 16'h000a;
  localparam logic [6:0] TOL_RST = 7'h05;
  localparam int EV_DERR = 0;
  localparam int EV_DPASS = 1;
  localparam int EV_APASS = 2;
  localparam int EV_AOVF = 3;
  localparam logic [1:0] DIAG_DISC = 2'h1;
  localparam logic [1:0] DIAG_OVF = 2'h2;

  // ==========================================================
  // Codes
  localparam logic [15:0] ERR_DIG_UNLOC = 16'h1f18;
  localparam logic [ANA_W-1:0] ANA_OVF = 16'h7fff;
  localparam logic [ANA_W-1:0] ANA_UDF = 16'h8000;
  localparam logic [ANA_W-1:0] ANA_FULL = 16'h6c00;
  localparam logic [6:0] PCT_DIV = 7'h64;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [DIG_W-1:0] a;
    logic [DIG_W-1:0] b;
  } dig_pair_t;

  typedef struct packed {
    logic [ANA_W-1:0] a;
    logic [ANA_W-1:0] b;
  } ana_pair_t;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [TMR_W-1:0] disc;
    logic [6:0] tol;
    logic [DIG_W-1:0] d_mark;
    logic [DIG_W-1:0] d_exp;
    logic [DIG_W-1:0] d_last;
    logic [DIG_W-1:0] d_pass_a;
    logic [DIG_W-1:0] d_pass_b;
    logic [DIG_W-1:0] d_prev_a;
    logic [DIG_W-1:0] d_prev_b;
    logic [DIG_W-1:0][TMR_W-1:0] d_tmr;
    logic [DIG_W-1:0] d_img;
    logic a_mark;
    logic a_pass_a;
    logic a_pass_b;
    logic [TMR_W-1:0] a_tmr;
    logic [ANA_W-1:0] a_last;
    logic [ANA_W-1:0] a_img;
    logic [EV_W-1:0] irq_sts;
    logic [EV_W-1:0] irq_en;
    logic [15:0] err;
    logic err_pulse;
    logic [DIAG_DEPTH-1:0][2:0] diag;
    logic [DIAG_PW-1:0] wr;
    logic [DIAG_PW-1:0] rd;
    logic [DIAG_PW:0] cnt;
    logic [31:0] prdata;
  } state_t;

endpackage

// >>> voter_sva.sv
// Port-level checks for the redundant input voter.
// Assumes update tick, inputs and APB all run on clock_in.
`timescale 1ns/1ps
module voter_sva
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Voting
  input wire logic update_tick_in,
  input wire voter_pkg::dig_pair_t dig_in,
  input wire voter_pkg::ana_pair_t ana_in,
  input wire logic [voter_pkg::DIG_W-1:0] dig_image_out,
  input wire logic [voter_pkg::ANA_W-1:0] ana_image_out,
  input wire logic unloc_err_out,
  input wire logic irq_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // Sequences
  sequence s_setup_access;
    psel_in && !penable_in ##1 psel_in && penable_in;
  endsequence
  // Channel B must be usable, else both are out
  sequence s_a_bad;
    update_tick_in && (ana_in.a == voter_pkg::ANA_OVF || ana_in.a == voter_pkg::ANA_UDF)
      && ana_in.b != voter_pkg::ANA_OVF && ana_in.b != voter_pkg::ANA_UDF;
  endsequence
  // ==========
  // Properties
  a_dig_agree: assert property (update_tick_in && dig_in.a == dig_in.b |=> dig_image_out == $past(dig_in.a))
    else $error("digital image is not the agreed value");
  a_ana_agree: assert property (update_tick_in && ana_in.a == ana_in.b && ana_in.a != voter_pkg::ANA_OVF
    && ana_in.a != voter_pkg::ANA_UDF |=> ana_image_out == $past(ana_in.a))
    else $error("analog image is not the agreed value");
  a_bad_reading: assert property (s_a_bad |=> ana_image_out == $past(ana_in.b))
    else $error("out-of-range channel still feeds image");
  a_image_stands: assert property (!update_tick_in |=> $stable(dig_image_out) && $stable(ana_image_out))
    else $error("image moved without a tick");
  a_unloc_cause: assert property (unloc_err_out |-> $past(update_tick_in) && $past(dig_in.a) != $past(dig_in.b))
    else $error("unlocalized error without a disagreeing tick");
  a_unloc_pulse: assert property (unloc_err_out |=> !unloc_err_out)
    else $error("unlocalized error longer than one cycle");
  a_irq_cause: assert property ($rose(irq_out) |-> $past(update_tick_in) || $past(pwrite_in) && $past(penable_in))
    else $error("interrupt rose without event or write");
  a_zero_wait: assert property (s_setup_access |-> pready_out)
    else $error("access phase not answered at once");
  a_bad_addr: assert property (psel_in && penable_in && (paddr_in[31:8] != 24'h0 || paddr_in[1:0] != 2'h0
    || paddr_in[7:0] > 8'h38) |-> pslverr_out)
    else $error("unmapped access not refused");
endmodule

bind redundant_input_voter voter_sva chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .update_tick_in(update_tick_in), .dig_in(dig_in), .ana_in(ana_in),
  .dig_image_out(dig_image_out), .ana_image_out(ana_image_out), .unloc_err_out(unloc_err_out), .irq_out(irq_out));
